// ### core/ocs4_curve.sv
// Curve engine: per-tick operate increment and reset decrement.
// Assumes ratio in Q8.8 and a multiplier already clamped to range.
`timescale 1ns/1ps
module ocs4_curve import ocs4_pkg::*; (
  input wire logic sys_clk,               // 20 MHz clock
  input wire logic rst,                   // Async reset, high
  input wire logic ce,                    // Clock enable
  input wire logic [15:0] ratio,          // Current over pickup, Q8.8
  input wire ocs4_curve_e curve_select,   // Operate curve
  input wire logic [12:0] mult,           // Multiplier, hundredths
  output logic [OCS4_FS_W:0] op_incr,     // Counter rise per tick
  output logic [OCS4_FS_W:0] rst_decr     // Counter fall per tick
);

  // ----------------------------------------------------------------
  // Logarithm and powers
  // ----------------------------------------------------------------
  logic [3:0] msb;        // Leading one position
  logic [63:0] rn;        // Normalised ratio
  logic [63:0] lnr;       // ln(I), Q16, zero below one
  logic [63:0] r2;        // I squared, Q16
  logic [63:0] x04;       // 0.4 ln I
  logic [63:0] den;       // Curve denominator, Q16
  logic [63:0] tb;        // Base time, 0.1 ms
  logic [63:0] tk;        // Operate time, ticks
  logic [63:0] rden;      // Reset denominator, Q16
  logic [63:0] tr;        // Reset time, ticks
  logic [63:0] scale;     // Units per tick times M divisor
  logic [63:0] fs;        // Full scale

  assign scale = 64'(OCS4_M_DIV * OCS4_UNITS_PER_MS * OCS4_TICK_MS);
  assign fs = 64'h1 << OCS4_FS_W;
  assign rn = {48'h0, ratio} << (4'd15 - msb);
  assign r2 = {48'h0, ratio} * {48'h0, ratio};
  assign x04 = (lnr * OCS4_A04) >> 16;

  // Leading-one search and piecewise-linear log2
  always_comb begin
    msb = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (ratio[i]) msb = 4'(i);
    end
    if (ratio < 16'h0100) lnr = 64'h0;  // Timing never runs below one
    else lnr = ((({60'h0, msb} - 64'(OCS4_RATIO_FRAC)) << 16)
                + {48'h0, rn[14:0], 1'b0}) * OCS4_LN2 >> 16;
  end

  // Denominator per curve; I^a - 1 direct for whole a, by series on ln I otherwise
  always_comb begin
    case (curve_select)
      std_normal_inverse, family2_moderate_inverse, family4_normal_inverse:
        den = (lnr * OCS4_A002) >> 16;
      std_very_inverse, long_inverse_a, family3_very_inverse, family3_long_inverse:
        den = ({48'h0, ratio} << OCS4_RATIO_FRAC) - OCS4_ONE;
      std_extreme_inverse, family2_very_inverse, family2_extreme_inverse:
        den = r2 - OCS4_ONE;
      long_inverse_b: den = {48'h0, ratio} << OCS4_RATIO_FRAC;
      family3_normal_inverse:
        den = x04 + ((x04 * x04) >> 17) + (x04 * x04 * x04) / (64'd6 << 32);
      family4_very_inverse:
        den = ((r2 * (OCS4_ONE - ((lnr * OCS4_A005) >> 16))) >> 16) - OCS4_ONE;
      fixed_time_curve: den = OCS4_ONE;  // Current independent
      default: den = 64'h0;
    endcase
    if (ratio < 16'h0100) den = 64'h0;   // Below pickup: base time saturates at OCS4_TB_SAT
  end

  // ----------------------------------------------------------------
  // Times and rates
  // ----------------------------------------------------------------
  always_comb begin
    tb = ocs4_sat_div(OCS4_K[curve_select] << 16, den);
    if (tb > OCS4_TB_SAT) tb = OCS4_TB_SAT;
    tb = tb + OCS4_C[curve_select];
    tk = tb * {51'h0, mult} / scale;
    if (tk == 64'h0) tk = 64'h1;
    rden = (ratio < 16'h0100) ? OCS4_ONE - r2 : 64'h0;
    tr = ocs4_sat_div(OCS4_RST_K << 16, rden);
    if (tr > OCS4_TB_SAT) tr = OCS4_TB_SAT;
    tr = tr * {51'h0, mult} / scale;
    if (tr == 64'h0) tr = 64'h1;
  end

  // Registered rates; a rate of one keeps even slow curves moving
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_incr <= '0;
      rst_decr <= '0;
    end else if (ce) begin
      op_incr <= (tk >= fs) ? 25'h1 : 25'(fs / tk);
      rst_decr <= (rden == 64'h0) ? 25'h0 : (tr >= fs) ? 25'h1 : 25'(fs / tr);
    end
  end

endmodule : ocs4_curve

// ### core/ocs4_pkg.sv
// Shared constants, types and helpers for overcurrent stage four.
// Assumes a 20 MHz sys_clk and current inputs in one common unit.
package ocs4_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OCS4_CLK_NS = 50;            // Clock period
  localparam int OCS4_NS_PER_MS = 1000000;    // Unit conversion
  localparam int OCS4_TICK_MS = 1;            // Processing tick
  localparam int OCS4_TICK_CYC = OCS4_TICK_MS * OCS4_NS_PER_MS / OCS4_CLK_NS;
  localparam int OCS4_MAINS_MS = 20;          // One power cycle, 50 Hz
  localparam int OCS4_HARM_CYC = OCS4_MAINS_MS * OCS4_NS_PER_MS / OCS4_CLK_NS;
  localparam int OCS4_HARM_REL_CYC = 3 * OCS4_HARM_CYC / 2; // 1.5 cycles
  localparam int OCS4_OFFDELAY_MS = 200;      // Contact off-delay
  localparam int OCS4_OFFDELAY_TICKS = OCS4_OFFDELAY_MS / OCS4_TICK_MS;

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  localparam int OCS4_FS_W = 24;              // Operate counter full scale bits
  localparam int OCS4_MARGIN_NUM = 115;       // Pickup margin 1.15 ...
  localparam int OCS4_MARGIN_DEN = 100;       // ... as a fraction
  localparam logic [12:0] OCS4_M_MIN = 13'd25;   // Multiplier 0.25, hundredths
  localparam logic [12:0] OCS4_M_MAX = 13'd5000; // Multiplier 50.00
  localparam int OCS4_M_DIV = 1000;           // M/10 with M in hundredths
  localparam int OCS4_UNITS_PER_MS = 10;      // Curve constants in 0.1 ms
  localparam int OCS4_RATIO_FRAC = 8;         // Current ratio fraction bits
  localparam longint OCS4_ONE = 64'd65536;    // 1.0 in Q16
  localparam longint OCS4_LN2 = 64'd45426;    // ln 2 in Q16
  localparam longint OCS4_A002 = 64'd1311;    // Exponent 0.02 in Q16
  localparam longint OCS4_A04 = 64'd26214;    // Exponent 0.4 in Q16
  localparam longint OCS4_A005 = 64'd3277;    // 2 - 1.95 in Q16
  localparam longint OCS4_TB_SAT = 64'h0000_00FF_FFFF_FFFF; // Time clamp
  localparam longint OCS4_RST_K = 64'd80000;  // Reset constant 8 s

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    std_normal_inverse, std_very_inverse, std_extreme_inverse,
    long_inverse_a, long_inverse_b, fixed_time_curve,
    family2_moderate_inverse, family2_very_inverse, family2_extreme_inverse,
    family3_normal_inverse, family3_very_inverse, family3_long_inverse,
    family4_normal_inverse, family4_very_inverse
  } ocs4_curve_e;

  typedef enum logic [1:0] {
    inverse_time_mode, definite_time_mode, instant_mode
  } ocs4_reset_e;

  // Curve constants k and C, 0.1 ms units, in curve enum order
  localparam longint OCS4_K [14] = '{1400, 135000, 800000, 540000, 800000,
    20000, 515, 196100, 202000, 24000, 160000, 600000, 1100, 398500};
  localparam longint OCS4_C [14] = '{0, 0, 0, 0, 0, 0, 1140, 4910, 1217,
    12000, 4000, 0, 4200, 10840};

  // Division that saturates instead of failing on zero
  function automatic logic [63:0] ocs4_sat_div(input logic [63:0] n,
                                               input logic [63:0] d);
    ocs4_sat_div = (d == 64'h0) ? 64'hFFFF_FFFF_FFFF_FFFF : n / d;
  endfunction : ocs4_sat_div

endpackage : ocs4_pkg

// ### core/ocs4_stage.sv
// Overcurrent stage four: detection, curve timing, reset and trip.
// Assumes current_mag and pickup_setting share one unit and are
// synchronous to sys_clk; harm_ratio_over is the raw 2nd-harmonic test.
`timescale 1ns/1ps

// Notes on behaviour
// - Detect at pickup, or 1.15x with margin
// - Timer advances only at pickup, unrestrained
// - Trip once counter reaches operate time
// - Restraint ignored when its enable off
// - No trip while stage disabled
// - Held reset modes keep trip 200 ms
// - Instant reset releases trip within 50 ms
// - Inverse reset decays counter, releases trip 0.2 s
// - Multiplier 0.25..50.00, scales time M/10
// - Fourteen curves, three reset modes, general formula
// - Standard normal inverse 0.14, exponent 0.02
// - Standard very and extremely inverse curves
// - Two long-time inverse curves
// - Definite curve fixed two times M/10
// - Family two moderately inverse curve
// - Family two very and extreme curves
// - Family three normal and very inverse
// - Family three long-time inverse curve
// - Family four normal and very inverse
// - Restraint latches one cycle, releases 1.5
module ocs4_stage import ocs4_pkg::*; #(
  parameter int TICK_CYCLES = OCS4_TICK_CYC,         // Clocks per tick
  parameter int HARM_CYCLES = OCS4_HARM_CYC,         // One power cycle
  parameter int HARM_REL_CYCLES = OCS4_HARM_REL_CYC  // 1.5 power cycles
) (
  input wire logic sys_clk,                    // 20 MHz clock
  input wire logic rst,                        // Async reset, high
  input wire logic ce,                         // Clock enable
  input wire logic stage_enable,               // Stage in use
  input wire logic harmonic_restraint_enable,  // Restraint in use
  input wire logic pickup_margin_enable,       // Detect at 1.15 x pickup
  input wire ocs4_curve_e curve_select,        // Operate curve
  input wire ocs4_reset_e reset_select,        // Reset characteristic
  input wire logic [12:0] time_multiplier,     // M in hundredths
  input wire logic [15:0] pickup_setting,      // Pickup current
  input wire logic [15:0] current_mag,         // Measured current
  input wire logic harm_ratio_over,            // Raw 2nd harmonic condition
  output logic trip,                           // Trip contact drive
  output logic pickup_detect,                  // Detection flag
  output logic harm_restraint,                 // Latched restraint flag
  output logic [OCS4_FS_W:0] operate_count     // Internal operate counter
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [OCS4_FS_W:0] FULL = (OCS4_FS_W + 1)'(1) << OCS4_FS_W;

  logic [23:0] tick_cnt_q;     // Tick prescaler
  logic tick;                  // One clock per processing tick
  logic [23:0] harm_cnt_q;     // Harmonic hold or release timer
  logic harm_q;                // Restraint latch
  logic restrain;              // Restraint as seen by this stage
  logic over_pick;             // Current at or above pickup
  logic over_margin;           // Current at or above 1.15 x pickup
  logic det_cond;              // Detection condition
  logic run;                   // Timing condition
  logic [15:0] ratio;          // I over pickup, Q8.8
  logic [63:0] ratio_w;        // Unclamped ratio
  logic [12:0] mult;           // Clamped multiplier
  logic [OCS4_FS_W:0] incr;    // Operate rate per tick
  logic [OCS4_FS_W:0] decr;    // Reset decay per tick
  logic [OCS4_FS_W:0] acc_q;   // Operate counter
  logic [OCS4_FS_W:0] acc_d;   // Next operate counter
  logic [OCS4_FS_W+1:0] acc_sum; // Counter plus rate, one spare bit
  logic det_q;                 // Registered detection
  logic trip_q;                // Registered trip
  logic trip_d;                // Next trip
  logic [7:0] od_q;            // Off-delay ticks since detection dropped
  logic od_done;               // Off-delay expired

  // ----------------------------------------------------------------
  // Tick generator
  // ----------------------------------------------------------------
  assign tick = ce && (tick_cnt_q == 24'(TICK_CYCLES - 1));

  // Free-running prescaler; ticks keep curve time independent of clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tick_cnt_q <= 24'h0;
    else if (ce) tick_cnt_q <= tick ? 24'h0 : tick_cnt_q + 24'h1;
  end

  // ----------------------------------------------------------------
  // Harmonic restraint latch
  // ----------------------------------------------------------------
  // One counter serves both directions: hold time while the latch is
  // clear, release time while it is set; any bounce restarts it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      harm_cnt_q <= 24'h0;
      harm_q <= 1'b0;
    end else if (ce) begin
      if (harm_ratio_over == harm_q) begin
        harm_cnt_q <= 24'h0;                               // Steady, no timing
      end else if (!harm_q && harm_cnt_q == 24'(HARM_CYCLES - 1)) begin
        harm_q <= 1'b1;
        harm_cnt_q <= 24'h0;
      end else if (harm_q && harm_cnt_q == 24'(HARM_REL_CYCLES - 1)) begin
        harm_q <= 1'b0;
        harm_cnt_q <= 24'h0;
      end else begin
        harm_cnt_q <= harm_cnt_q + 24'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Detection and timing conditions
  // ----------------------------------------------------------------
  assign restrain = harmonic_restraint_enable && harm_q;
  assign over_pick = current_mag >= pickup_setting;
  // Cross-multiply rather than divide by 1.15
  assign over_margin = (24'(current_mag) * 24'(OCS4_MARGIN_DEN))
                       >= (24'(pickup_setting) * 24'(OCS4_MARGIN_NUM));
  assign det_cond = stage_enable && !restrain
                    && (pickup_margin_enable ? over_margin : over_pick);
  // Timing always uses plain pickup, so the margin only delays detection
  assign run = stage_enable && !restrain && over_pick;

  // ----------------------------------------------------------------
  // Curve inputs
  // ----------------------------------------------------------------
  assign ratio_w = ocs4_sat_div({40'h0, current_mag, 8'h00},
                                {48'h0, pickup_setting});
  assign ratio = (ratio_w > 64'hFFFF) ? 16'hFFFF : ratio_w[15:0];
  // Out-of-range settings are clamped, never rejected
  assign mult = (time_multiplier < OCS4_M_MIN) ? OCS4_M_MIN :
                (time_multiplier > OCS4_M_MAX) ? OCS4_M_MAX :
                time_multiplier;

  // Curve engine: rates for the selected curve and reset
  ocs4_curve u_curve (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .ratio(ratio),
    .curve_select(curve_select),
    .mult(mult),
    .op_incr(incr),
    .rst_decr(decr)
  );

  // ----------------------------------------------------------------
  // Operate counter
  // ----------------------------------------------------------------
  assign acc_sum = {1'b0, acc_q} + {1'b0, incr};

  // Counts up along the curve, saturating at full scale
  always_comb begin
    acc_d = acc_q;
    if (!stage_enable) begin
      acc_d = '0;
    end else if (run) begin
      if (tick) acc_d = (acc_sum >= {1'b0, FULL}) ? FULL : acc_sum[OCS4_FS_W:0];
    end else if (reset_select == inverse_time_mode) begin
      if (tick) acc_d = (acc_q > decr) ? acc_q - decr : '0;
    end else begin
      acc_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // Trip and off-delay
  // ----------------------------------------------------------------
  assign od_done = (od_q == 8'(OCS4_OFFDELAY_TICKS));

  // Set on full count, released per reset characteristic
  always_comb begin
    trip_d = trip_q;
    if (!stage_enable) begin
      trip_d = 1'b0;
    end else if (det_cond && acc_q >= FULL) begin
      trip_d = 1'b1;
    end else if (!det_cond && reset_select == instant_mode) begin
      trip_d = 1'b0;
    end else if (!det_cond && od_done) begin
      trip_d = 1'b0;
    end
  end

  // State registers; ce low freezes everything
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      trip_q <= 1'b0;
      det_q <= 1'b0;
      od_q <= 8'h0;
    end else if (ce) begin
      acc_q <= acc_d;
      trip_q <= trip_d;
      det_q <= det_cond;
      if (det_cond || !trip_q) od_q <= 8'h0;               // Restart hold
      else if (tick && !od_done) od_q <= od_q + 8'h1;
    end
  end

  assign trip = trip_q;
  assign pickup_detect = det_q;
  assign harm_restraint = harm_q;
  assign operate_count = acc_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Detection dropped while tripped under a held reset mode
  sequence s_hold_start;
    ce && stage_enable && trip_q && !det_cond && reset_select != instant_mode
    && od_q == 8'h0;
  endsequence

  sequence s_stay_low;
    !det_cond && stage_enable && reset_select != instant_mode;
  endsequence

  a_margin_detect: assert property (ce && pickup_margin_enable && !over_margin
    |=> !pickup_detect) else $error("detected below margin");
  a_restraint_ignored: assert property (ce && !harmonic_restraint_enable
    && stage_enable && over_pick && !pickup_margin_enable |=> pickup_detect)
    else $error("restraint blocked with enable off");
  a_count_advance: assert property (tick && run && acc_q < FULL && incr != '0
    |=> acc_q > $past(acc_q)) else $error("counter did not advance");
  a_count_frozen: assert property (ce && stage_enable && restrain
    && reset_select != inverse_time_mode |=> acc_q == '0)
    else $error("counter ran under restraint");
  a_trip_cause: assert property ($rose(trip) |-> $past(det_cond)
    && $past(acc_q) == FULL) else $error("trip without full count");
  a_disabled_quiet: assert property (ce && !stage_enable |=> !trip
    && operate_count == '0) else $error("disabled stage active");
  a_offdelay_hold: assert property (s_hold_start ##1 s_stay_low [*8]
    |-> trip) else $error("trip released early");
  a_instant_release: assert property (ce && reset_select == instant_mode
    && !det_cond |=> !trip) else $error("instant reset late");
  a_inverse_time_mode_decay: assert property (tick && !run && stage_enable
    && reset_select == inverse_time_mode && acc_q != '0 && decr != '0
    |=> acc_q < $past(acc_q)) else $error("counter did not decay");
  a_count_cleared: assert property (ce && !run
    && reset_select != inverse_time_mode |=> acc_q == '0)
    else $error("counter not cleared");
  a_mult_range: assert property (mult >= OCS4_M_MIN && mult <= OCS4_M_MAX)
    else $error("multiplier out of range");
  a_harm_latch: assert property ($rose(harm_q) |-> $past(harm_cnt_q)
    == 24'(HARM_CYCLES - 1)) else $error("restraint latched early");
  a_harm_release: assert property ($fell(harm_q) |-> $past(harm_cnt_q)
    == 24'(HARM_REL_CYCLES - 1)) else $error("restraint released early");
  a_tick_period: assert property (tick |=> !tick)
    else $error("tick too frequent");

endmodule : ocs4_stage

// ### testbench/ocs4_front_model.sv
// Front-end model: measurement path feeding the stage current input.
// Assumes the bench commands the primary current at sys_clk edges.
`timescale 1ns/1ps
module ocs4_front_model (
  input wire logic sys_clk, // Processing clock
  input wire logic rst, // Async reset, high
  input wire logic [15:0] amps_cmd, // Commanded current
  output logic [15:0] current_mag // Measured magnitude
);
  // ----------------------------------------------------------------
  // Measurement latency
  // ----------------------------------------------------------------
  // One cycle late, like a real filter stage; zero under reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      current_mag <= 16'h0000;
    end else begin
      current_mag <= amps_cmd;
    end
  end
endmodule : ocs4_front_model

// ### testbench/testbench.sv
// Self-checking bench for overcurrent stage four.
// Assumes short tick and harmonic-window parameters on the stage.
`timescale 1ns/1ps
module testbench import ocs4_pkg::*;
  ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, st_en = 1'b1; // Clock, reset, enables
  logic hr_en = 1'b0, mg_en = 1'b0, hro = 1'b0; // Restraint and margin
  ocs4_curve_e cs = fixed_time_curve; // Operate curve
  ocs4_reset_e rs = instant_mode; // Reset mode
  logic [12:0] tm = 13'h0019; // Multiplier 0.25
  logic [15:0] pk = 16'h0064, amps = 16'h0000, cur; // Pickup 100, current
  logic trip, det, hr; // Stage outputs
  logic [OCS4_FS_W:0] cnt; // Operate counter
  int fail_count = 0, checks_done = 0, n; // Counters
  real kk[15] = '{0.14, 13.5, 80, 54, 80, 2, 0.0515, 19.61, 20.2, 2.4, 16, 60, 0.11, 39.85, 2};
  real aa[15] = '{0.02, 1, 2, 1, 0, 0, 0.02, 2, 2, 0.4, 1, 1, 0.02, 1.95, 0};
  real cc[15] = '{0, 0, 0, 0, 0, 0, 0.114, 0.491, 0.1217, 1.2, 0.4, 0, 0.42, 1.084, 0};
  real den, ex; // Expected cycles at I = 10
  initial forever #25 sys_clk = ~sys_clk;
  ocs4_front_model fm (.sys_clk(sys_clk), .rst(rst), .amps_cmd(amps), .current_mag(cur));
  ocs4_stage #(.TICK_CYCLES(4), .HARM_CYCLES(8), .HARM_REL_CYCLES(12)) dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .stage_enable(st_en),
    .harmonic_restraint_enable(hr_en), .pickup_margin_enable(mg_en), .curve_select(cs),
    .reset_select(rs), .time_multiplier(tm), .pickup_setting(pk), .current_mag(cur),
    .harm_ratio_over(hro), .trip(trip), .pickup_detect(det), .harm_restraint(hr),
    .operate_count(cnt));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Sample just after the edge so register updates have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic drive(input logic [15:0] a);
    @(posedge sys_clk);
    amps <= a;
  endtask : drive
  // Bounded wait; a hang shows up as a count of 3000
  task automatic time_trip(output int k);
    k = 0;
    while (trip !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask : time_trip
  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Watchdog, well above the roughly 7400 cycles of the tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    chk({trip, cnt}, 0);
    // Every curve at ten times pickup; fixed time at M 0 (clamped) and M 0.50
    for (int i = 0; i < 15; i++) begin
      @(posedge sys_clk);
      cs <= ocs4_curve_e'((i == 14) ? 5 : i);
      tm <= (i == 14) ? 13'h0032 : (i == 5) ? 13'h0000 : 13'h0019;
      den = (i == 4) ? 10.0 : ((i == 5 || i == 14) ? 1.0 : $pow(10.0, aa[i]) - 1.0);
      ex = (kk[i] / den + cc[i]) * ((i == 14) ? 0.05 : 0.025) * 4000.0;
      drive(16'h03E8);
      time_trip(n);
      chk(n >= 0.9 * ex - 16 && n <= 1.1 * ex + 16, 1);
      chk(cnt, 32'h0100_0000);
      drive(16'h0000);
      cyc(3);
      chk({trip, cnt}, 0);
    end
    // Definite and inverse reset both hold the contact 200 ticks
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk);
      rs <= (j == 0) ? definite_time_mode : inverse_time_mode;
      drive(16'h03E8);
      time_trip(n);
      drive(16'h0000);
      cyc(12);
      if (j == 0) chk(cnt, 0);
      else chk(cnt > 0 && cnt < 25'h100_0000, 1);
      cyc(740);
      chk(trip, 1);
      cyc(70);
      chk(trip, 0);
    end
    // Disabled stage never trips
    @(posedge sys_clk);
    rs <= instant_mode;
    st_en <= 1'b0;
    drive(16'h03E8);
    cyc(300);
    chk({trip, cnt}, 0);
    @(posedge sys_clk);
    st_en <= 1'b1;
    // Detection boundaries with and without the 1.15 margin
    mg_en <= 1'b1;
    drive(16'h0072);
    cyc(3);
    chk(det, 0);
    drive(16'h0073);
    cyc(3);
    chk(det, 1);
    @(posedge sys_clk);
    mg_en <= 1'b0;
    drive(16'h0063);
    cyc(3);
    chk(det, 0);
    drive(16'h0064);
    cyc(3);
    chk(det, 1);
    drive(16'h0000);
    // Restraint latch, blocking, bypass and release
    @(posedge sys_clk);
    hr_en <= 1'b1;
    hro <= 1'b1;
    cyc(5);
    chk(hr, 0);
    cyc(6);
    chk(hr, 1);
    drive(16'h03E8);
    cyc(40);
    chk({det, cnt}, 0);
    @(posedge sys_clk);
    hr_en <= 1'b0;
    cyc(3);
    chk(det, 1);
    // Clock enable low must freeze the running counter
    @(posedge sys_clk);
    ce <= 1'b0;
    cyc(1);
    n = cnt;
    cyc(20);
    chk(cnt, n);
    @(posedge sys_clk);
    ce <= 1'b1;
    hro <= 1'b0;
    cyc(9);
    chk(hr, 1);
    cyc(6);
    chk(hr, 0);
    drive(16'h0000);
    cyc(4);
    finish_test();
  end
endmodule : testbench
